// ### hdl/twsp_eight_bit_timer.sv
`timescale 1ns/1ns
// Notes on behaviour
// - in timer mode without prescaler the count register steps once per instruction period.
// - a software write to the count register holds off counting for the next two instruction periods.
// - clock_source_select (bit 5) picks external pin edges when 1, the instruction clock when 0.
// - ext_edge_select (bit 4) counts falling pin edges when 1, rising ones when 0.
// - prescaler_assign (bit 3) gives the one prescaler to the timer when 0, to the watchdog when 1.
// - prescaler_ratio divides by 2 to 256 for the timer, by 1 to 128 for the watchdog, doubling per step.
// - the timer counts undivided only while the prescaler belongs to the watchdog.
// - the prescaler is invisible to software and a count write clears it while the timer owns it.
// - a watchdog clear clears the prescaler and the watchdog while the watchdog owns the prescaler.
// - a rollover from ff to 00 sets the overflow flag whatever the enable.
// - the flag stays until software clears it and a request is raised only while enabled.
// - the timer stands still in sleep so its overflow cannot wake the core.
// - the flag sits at bit 2 and the enable at bit 5 of the interrupt control register, both read/write.
// - reset leaves the count register value as it was.
module twsp_eight_bit_timer #(
	parameter int ADDR_W = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// external count pin
	input wire logic ext_count_pin,
	// watchdog side
	input wire logic wdt_base_tick,
	output logic wdt_timeout_tick,
	output logic wdt_clear,
	// interrupt request
	output logic overflow_irq
);

	generate
		if (ADDR_W < 10) begin : g_addr_check
			$error("ADDR_W too small for the register map");
		end
	endgenerate

	logic [7:0] eight_bit_timer_count_reg;
	twsp_pkg::twsp_option_t option_reg;
	twsp_pkg::twsp_intctl_t intctl_reg;
	logic sleep_reg;
	logic [7:0] pre_reg;
	logic [1:0] div_reg;
	logic [1:0] inhibit_reg;
	logic pin_s1_reg, pin_s2_reg, pin_s3_reg;

	logic [7:0] index;
	logic access_done;
	logic wr_go;
	logic count_wr, option_wr, intctl_wr, core_wr;
	logic wdt_clr_cmd;
	logic instr_tick;
	logic ext_edge;
	logic src_evt;
	logic pre_in;
	logic [7:0] pre_mask;
	logic pre_hit;
	logic pre_clear;
	logic timer_inc;
	logic overflow_set;
	// count holds no value until the first load, and reset does not clear it
	logic count_loaded_reg = 1'b0;

	// mask of low prescaler bits that must be all ones for one output
	function automatic logic [7:0] ratio_mask(input logic [2:0] ratio, input logic to_wdt);
		logic [8:0] span;
		span = 9'h001 << ratio;
		if (!to_wdt) begin
			span = span << 1;
		end
		return 8'(span - 9'h001);
	endfunction

	// bus decode; a write lands at the edge where waitrequest is seen low
	assign index = address[9:2];
	assign access_done = (read || write) && !waitrequest;
	assign wr_go = write && !waitrequest && byteenable[0];
	always_comb begin
		count_wr = 1'b0;
		option_wr = 1'b0;
		intctl_wr = 1'b0;
		core_wr = 1'b0;
		if (index == twsp_pkg::IDX_COUNT) begin
			count_wr = wr_go;
		end else if (index == twsp_pkg::IDX_OPTION) begin
			option_wr = wr_go;
		end else if (index == twsp_pkg::IDX_INTCTL) begin
			intctl_wr = wr_go;
		end else if (index == twsp_pkg::IDX_CORE) begin
			core_wr = wr_go;
		end
	end
	assign wdt_clr_cmd = core_wr && writedata[twsp_pkg::CORE_WDTCLR_BIT];

	// one wait cycle, then the answer; back to waiting after each transfer
	always_ff @(posedge clk) begin
		if (reset) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// prescaler never appears on the bus; unmapped reads give zero
	// prescaler hidden
	always_ff @(posedge clk) begin
		if (reset) begin
			readdata <= 32'h0000_0000;
		end else if (read && waitrequest) begin
			if (index == twsp_pkg::IDX_COUNT) begin
				readdata <= {24'h000000, eight_bit_timer_count_reg};
			end else if (index == twsp_pkg::IDX_OPTION) begin
				readdata <= {24'h000000, option_reg};
			end else if (index == twsp_pkg::IDX_INTCTL) begin
				readdata <= 32'(intctl_reg.overflow_irq_enable) << twsp_pkg::INTCTL_IRQEN_BIT
					| 32'(intctl_reg.overflow_flag) << twsp_pkg::INTCTL_FLAG_BIT;
			end else if (index == twsp_pkg::IDX_CORE) begin
				readdata <= 32'(sleep_reg) << twsp_pkg::CORE_SLEEP_BIT;
			end else begin
				readdata <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			option_reg <= twsp_pkg::OPTION_RESET;
		end else if (option_wr) begin
			option_reg <= writedata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sleep_reg <= 1'b0;
		end else if (core_wr) begin
			sleep_reg <= writedata[twsp_pkg::CORE_SLEEP_BIT];
		end
	end

	// instruction period enable
	always_ff @(posedge clk) begin
		if (reset) begin
			div_reg <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
		end
	end
	assign instr_tick = (div_reg == twsp_pkg::INSTR_LAST);

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			pin_s3_reg <= 1'b0;
		end else begin
			pin_s1_reg <= ext_count_pin;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	assign ext_edge = option_reg.ext_edge_select ? (pin_s3_reg && !pin_s2_reg) : (pin_s2_reg && !pin_s3_reg);

	assign src_evt = !sleep_reg && (option_reg.clock_source_select ? ext_edge : instr_tick);

	assign pre_in = option_reg.prescaler_assign ? wdt_base_tick : src_evt;
	assign pre_mask = ratio_mask(option_reg.prescaler_ratio, option_reg.prescaler_assign);
	assign pre_hit = pre_in && ((pre_reg & pre_mask) == pre_mask);

	assign pre_clear = (count_wr && !option_reg.prescaler_assign) || (wdt_clr_cmd && option_reg.prescaler_assign);

	always_ff @(posedge clk) begin
		if (reset || pre_clear) begin
			pre_reg <= 8'h00;
		end else if (pre_in) begin
			pre_reg <= pre_reg + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			inhibit_reg <= 2'h0;
		end else if (count_wr) begin
			inhibit_reg <= twsp_pkg::WRITE_INHIBIT_PERIODS;
		end else if (instr_tick && inhibit_reg != 2'h0) begin
			inhibit_reg <= inhibit_reg - 2'h1;
		end
	end

	assign timer_inc = (inhibit_reg == 2'h0) && (option_reg.prescaler_assign ? src_evt : pre_hit);

	// no reset branch: the count survives a device reset
	// count kept
	always_ff @(posedge clk) begin
		if (count_wr) begin
			eight_bit_timer_count_reg <= writedata[7:0];
		end else if (timer_inc) begin
			eight_bit_timer_count_reg <= eight_bit_timer_count_reg + 8'h01;
		end
	end

	// checks on the count wait for its first load
	always_ff @(posedge clk) begin
		if (count_wr) begin
			count_loaded_reg <= 1'b1;
		end
	end

	assign overflow_set = timer_inc && !count_wr && (eight_bit_timer_count_reg == 8'hff);

	// set beats a same-cycle software clear
	// sticky flag
	always_ff @(posedge clk) begin
		if (reset) begin
			intctl_reg <= twsp_pkg::INTCTL_RESET[1:0];
		end else begin
			if (intctl_wr) begin
				intctl_reg.overflow_irq_enable <= writedata[twsp_pkg::INTCTL_IRQEN_BIT];
			end
			if (overflow_set) begin
				intctl_reg.overflow_flag <= 1'b1;
			end else if (intctl_wr) begin
				intctl_reg.overflow_flag <= writedata[twsp_pkg::INTCTL_FLAG_BIT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			overflow_irq <= 1'b0;
		end else begin
			overflow_irq <= intctl_reg.overflow_flag && intctl_reg.overflow_irq_enable;
		end
	end

	// watchdog runs 1:1 while the timer owns the prescaler
	always_ff @(posedge clk) begin
		if (reset) begin
			wdt_timeout_tick <= 1'b0;
			wdt_clear <= 1'b0;
		end else begin
			wdt_timeout_tick <= option_reg.prescaler_assign ? pre_hit : wdt_base_tick;
			wdt_clear <= wdt_clr_cmd;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_timer_mode_step: assert property (
		count_loaded_reg && !option_reg.clock_source_select && option_reg.prescaler_assign && instr_tick && !sleep_reg
		&& inhibit_reg == 2'h0 && !count_wr |=> eight_bit_timer_count_reg == $past(eight_bit_timer_count_reg) + 8'h01)
		else $error("timer mode did not step");

	a_write_holdoff: assert property (
		count_wr |=> ##1 ($stable(eight_bit_timer_count_reg) || count_wr)[*4])
		else $error("count moved during write hold-off");

	a_pin_edge_step: assert property (
		count_loaded_reg && option_reg.clock_source_select && option_reg.prescaler_assign && ext_edge && !sleep_reg
		&& inhibit_reg == 2'h0 && !count_wr |=> eight_bit_timer_count_reg == $past(eight_bit_timer_count_reg) + 8'h01)
		else $error("pin edge not counted");

	a_no_edge_still: assert property (
		count_loaded_reg && option_reg.clock_source_select && option_reg.prescaler_assign && !ext_edge && !count_wr
		|=> $stable(eight_bit_timer_count_reg))
		else $error("count moved without selected edge");

	a_ratio_holds: assert property (
		count_loaded_reg && !option_reg.prescaler_assign && ((pre_reg & pre_mask) != pre_mask) && !count_wr
		|=> $stable(eight_bit_timer_count_reg))
		else $error("timer stepped before prescaler ratio");

	a_count_write_clear: assert property (
		count_wr && !option_reg.prescaler_assign |=> pre_reg == 8'h00)
		else $error("count write left prescaler");

	a_wdt_clear_both: assert property (
		wdt_clr_cmd && option_reg.prescaler_assign |=> pre_reg == 8'h00 && wdt_clear)
		else $error("watchdog clear missed");

	a_rollover_flag: assert property (
		timer_inc && !count_wr && eight_bit_timer_count_reg == 8'hff
		|=> intctl_reg.overflow_flag && eight_bit_timer_count_reg == 8'h00)
		else $error("rollover did not set flag");

	a_irq_gated: assert property (
		!intctl_reg.overflow_irq_enable |=> !overflow_irq)
		else $error("request raised while disabled");

	a_sleep_frozen: assert property (
		count_loaded_reg && sleep_reg && option_reg.prescaler_assign && !count_wr |=> $stable(eight_bit_timer_count_reg))
		else $error("timer ran in sleep");

	a_prescaler_owner: assert property (
		option_reg.prescaler_assign && !wdt_base_tick && !wdt_clr_cmd |=> $stable(pre_reg))
		else $error("prescaler moved without watchdog tick");

	a_wdt_undivided: assert property (
		!option_reg.prescaler_assign && wdt_base_tick |=> wdt_timeout_tick)
		else $error("watchdog tick lost while timer owns prescaler");

	a_flag_sticky: assert property (
		intctl_reg.overflow_flag && !intctl_wr |=> intctl_reg.overflow_flag)
		else $error("overflow flag dropped by itself");

	a_flag_readable: assert property (
		read && waitrequest && index == twsp_pkg::IDX_INTCTL
		|=> readdata[twsp_pkg::INTCTL_FLAG_BIT] == $past(intctl_reg.overflow_flag))
		else $error("flag not shown at its bit");

	c_overflow: cover property (overflow_set);
	c_pin_count: cover property (option_reg.clock_source_select && timer_inc);
	c_prescaled_step: cover property (!option_reg.prescaler_assign && pre_hit && timer_inc);
	c_write_then_step: cover property (count_wr ##[1:20] timer_inc);

endmodule

// ### hdl/twsp_pkg.sv
package twsp_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_COUNT = 8'h01;
	localparam logic [7:0] IDX_OPTION = 8'h81;
	localparam logic [7:0] IDX_INTCTL = 8'h0b;
	localparam logic [7:0] IDX_CORE = 8'h02;

	// reset values
	localparam logic [7:0] OPTION_RESET = 8'hfb;
	localparam logic [7:0] INTCTL_RESET = 8'h00;

	// field positions in the interrupt control register
	localparam int INTCTL_FLAG_BIT = 2;
	localparam int INTCTL_IRQEN_BIT = 5;

	// field positions in the core control register
	localparam int CORE_SLEEP_BIT = 0;
	localparam int CORE_WDTCLR_BIT = 1;

	// timing: one instruction period is four system clocks
	localparam int INSTR_CLOCKS = 4;
	localparam logic [1:0] INSTR_LAST = 2'(INSTR_CLOCKS - 1);
	localparam logic [1:0] WRITE_INHIBIT_PERIODS = 2'h2;

	typedef struct packed {
		logic portb_pullup_disable;
		logic ext_irq_edge_select;
		logic clock_source_select;
		logic ext_edge_select;
		logic prescaler_assign;
		logic [2:0] prescaler_ratio;
	} twsp_option_t;

	typedef struct packed {
		logic overflow_irq_enable;
		logic overflow_flag;
	} twsp_intctl_t;

endpackage

// ### sim/twsp_eight_bit_timer_tb.sv
`timescale 1ns/1ns
module twsp_eight_bit_timer_tb;
	localparam logic [7:0] CNT = twsp_pkg::IDX_COUNT, OPT = twsp_pkg::IDX_OPTION;
	localparam logic [7:0] ICR = twsp_pkg::IDX_INTCTL, CORE = twsp_pkg::IDX_CORE;
	logic clk, reset, read, write, waitrequest, pin, src_go;
	logic wdt_base_tick, wdt_timeout_tick, wdt_clear, overflow_irq;
	logic [9:0] address;
	logic [31:0] writedata, readdata;
	logic [7:0] rd, a;
	int err_count, total_checks, wdt_ticks, clr_ticks;
	twsp_eight_bit_timer i_twsp_eight_bit_timer (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
		.byteenable(4'hf), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.ext_count_pin(pin), .wdt_base_tick(wdt_base_tick), .wdt_timeout_tick(wdt_timeout_tick),
		.wdt_clear(wdt_clear), .overflow_irq(overflow_irq));
	twsp_pulse_src i_twsp_pulse_src (.clk(clk), .start(src_go), .pin(pin));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		wdt_ticks <= wdt_ticks + int'(wdt_timeout_tick === 1'b1);
		clr_ticks <= clr_ticks + int'(wdt_clear === 1'b1);
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		if (err_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		{read, write} <= {~wr, wr};
		address <= {idx, 2'b00};
		writedata <= {24'h0, d};
		@(posedge clk);
		while (waitrequest !== 1'b0)
			@(posedge clk);
		rd = readdata[7:0];
		{read, write} <= 2'b00;
	endtask
	task automatic get(input logic [7:0] idx); bus(1'b0, idx, 8'h00); endtask
	task automatic put(input logic [7:0] idx, input logic [7:0] d); bus(1'b1, idx, d); endtask
	task automatic idle(input int n); repeat (n) @(posedge clk); endtask
	task automatic base(input int n);
		repeat (n) begin
			wdt_base_tick <= 1'b1;
			idle(1);
			wdt_base_tick <= 1'b0;
			idle(3);
		end
	endtask
	// count advance between two reads spaced n+2 clocks apart
	task automatic span(input int n);
		get(CNT);
		a = rd;
		idle(n - 1);
		get(CNT);
		a = rd - a;
	endtask
	task automatic t_timer;
		put(OPT, 8'hc8);
		put(CNT, 8'h10);
		span(37);
		check("held", 8'(a inside {8'h08, 8'h09}), 8'h01);
		span(37);
		check("plain", a, 8'h0a);
		put(CORE, 8'h01);
		span(37);
		check("sleep", a, 8'h00);
		put(CORE, 8'h00);
	endtask
	task automatic t_prescale;
		// clear the watchdog before handing the prescaler back
		put(CORE, 8'h02);
		for (int r = 0; r < 8; r++) begin
			put(OPT, 8'hc0 | 8'(r));
			put(CNT, 8'h00);
			idle(20);
			span((16 << r) - 3);
			check("ratio", a, 8'h02);
		end
	endtask
	task automatic t_overflow;
		put(OPT, 8'hc8);
		put(CNT, 8'hfe);
		idle(30);
		get(ICR);
		check("flag", rd, 8'h04);
		check("masked", 8'(overflow_irq), 8'h00);
		put(ICR, 8'h24);
		idle(2);
		check("irq", 8'(overflow_irq), 8'h01);
		put(ICR, 8'h20);
		idle(2);
		check("cleared", 8'(overflow_irq), 8'h00);
	endtask
	task automatic t_counter;
		for (int s = 0; s < 2; s++) begin
			put(OPT, s == 0 ? 8'he8 : 8'hf8);
			put(CNT, 8'h00);
			idle(12);
			src_go <= 1'b1;
			idle(1);
			src_go <= 1'b0;
			idle(40);
			get(CNT);
			check("edges", rd, 8'h02);
		end
	endtask
	task automatic t_wdt;
		int t, c;
		for (int r = 0; r < 4; r++) begin
			t = wdt_ticks;
			c = clr_ticks;
			put(CORE, 8'h02);
			put(OPT, 8'hc8 | 8'(r));
			put(CORE, 8'h02);
			base(3);
			put(CORE, 8'h02);
			base(5);
			check("clears", 8'(clr_ticks - c), 8'h03);
			check("timeouts", 8'(wdt_ticks - t), 8'((3 >> r) + (5 >> r)));
		end
	endtask
	initial begin
		reset = 1'b1;
		{read, write, src_go, wdt_base_tick} = 4'h0;
		address = 10'h000;
		writedata = 32'h0;
		idle(4);
		reset <= 1'b0;
		get(OPT);
		check("option", rd, twsp_pkg::OPTION_RESET);
		get(ICR);
		check("intctl", rd, twsp_pkg::INTCTL_RESET);
		t_timer;
		t_prescale;
		t_overflow;
		t_counter;
		t_wdt;
		close_out;
	end
	initial begin
		idle(20000);
		err_count++;
		close_out;
	end
endmodule

// ### sim/twsp_pulse_src.sv
`timescale 1ns/1ns
module twsp_pulse_src (
	// clock and request
	input wire logic clk,
	input wire logic start,
	// count pin
	output logic pin
);
	logic [4:0] left_reg = 5'h00;
	logic pin_reg = 1'b0;
	assign pin = pin_reg;
	// three toggles eight clocks apart, slow enough for the synchroniser
	always_ff @(posedge clk) begin
		if (start) begin
			left_reg <= 5'h18;
		end else if (left_reg != 5'h00) begin
			left_reg <= left_reg - 5'h01;
			pin_reg <= pin_reg ^ (left_reg[2:0] == 3'h1);
		end
	end
endmodule
